/* File: rtl/panel_operator_keypad_ui.sv */
/*
  Front-panel operator: key debounce, basic mode sequencing, status segments and codes,
  alarm clear requests, parameter selection and editing, plain register port.
  Assumes key and alarm reset pins are asynchronous; all other inputs come from the
  control core on i_core_clk.
*/
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module panel_operator_keypad_ui #(
  parameter int DEBOUNCE_CYCLES     = panel_pkg::DEBOUNCE_CYCLES,
  parameter int LONG_PRESS_CYCLES   = panel_pkg::LONG_PRESS_CYCLES,
  parameter int REPEAT_DELAY_CYCLES = panel_pkg::REPEAT_DELAY_CYCLES,
  parameter int REPEAT_START_CYCLES = panel_pkg::REPEAT_START_CYCLES,
  parameter int REPEAT_MIN_CYCLES   = panel_pkg::REPEAT_MIN_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_increment_key,
  input  wire logic        i_decrement_key,
  input  wire logic        i_mode_key,
  input  wire logic        i_enter_key,
  input  wire logic        i_alarm_reset_input,
  input  wire logic [1:0]  i_control_mode,
  input  wire logic [15:0] i_motor_speed,
  input  wire logic [15:0] i_speed_reference,
  input  wire logic [15:0] i_torque_reference,
  input  wire logic [15:0] i_position_error,
  input  wire logic        i_ref_pulse_active,
  input  wire logic        i_err_clear_input,
  input  wire logic        i_base_block,
  input  wire logic        i_control_power_on,
  input  wire logic        i_main_power_ok,
  input  wire logic        i_forward_overtravel,
  input  wire logic        i_reverse_overtravel,
  input  wire logic        i_alarm_active,
  input  wire logic [7:0]  i_alarm_code,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_basic_mode,
  output logic [6:0]       o_status_segments,
  output logic [2:0]       o_status_code,
  output logic [7:0]       o_alarm_code,
  output logic             o_alarm_clear,
  output logic [2:0]       o_param_number,
  output logic [15:0]      o_display_value,
  output logic [1:0]       o_edit_state,
  output logic             o_digit_shift
);

  // ==========================================================================
  // Pin synchronisers and debounce
  // ==========================================================================
  logic [panel_pkg::N_PINS-1:0] pin_raw;
  logic [panel_pkg::N_PINS-1:0] held;
  logic [panel_pkg::N_PINS-1:0] press;
  logic [panel_pkg::N_PINS-1:0] release_ev;

  assign pin_raw = {i_alarm_reset_input, i_enter_key, i_mode_key, i_decrement_key, i_increment_key};

  genvar k;
  generate
    for (k = 0; k < panel_pkg::N_PINS; k++) begin : g_pin
      logic [2:0]  sync;
      logic [31:0] cnt;
      logic        agree;
      logic        differ;
      logic        done;
      assign agree  = (sync[1] == sync[2]);
      assign differ = agree && (sync[2] != held[k]);
      assign done   = differ && (cnt == 32'(DEBOUNCE_CYCLES - 1));
      always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
          sync          <= 3'h0;
          cnt           <= 32'h0;
          held[k]       <= 1'b0;
          press[k]      <= 1'b0;
          release_ev[k] <= 1'b0;
        end else begin
          sync          <= {sync[1:0], pin_raw[k]};
          cnt           <= (differ && !done) ? cnt + 32'h1 : 32'h0;
          held[k]       <= done ? sync[2] : held[k];
          press[k]      <= done && sync[2];
          release_ev[k] <= done && !sync[2];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Chord, long press and auto repeat
  // ==========================================================================
  logic        chord_seen;
  logic        long_fired;
  logic [31:0] long_cnt;
  logic        long_press;
  logic [31:0] rep_cnt;
  logic [31:0] rep_int;
  logic        rep_tick;
  wire         both_held  = held[panel_pkg::PIN_MODE] && held[panel_pkg::PIN_ENTER];
  wire         chord_ev   = both_held && !chord_seen;
  wire         mode_act   = release_ev[panel_pkg::PIN_MODE] && !chord_seen;
  wire         enter_act  = release_ev[panel_pkg::PIN_ENTER] && !chord_seen && !long_fired;
  wire         one_held   = held[panel_pkg::PIN_INC] ^ held[panel_pkg::PIN_DEC];
  wire         any_step   = press[panel_pkg::PIN_INC] || press[panel_pkg::PIN_DEC];
  wire         long_hit   = held[panel_pkg::PIN_ENTER] && !chord_seen && !long_fired &&
                            (long_cnt == 32'(LONG_PRESS_CYCLES - 1));
  wire         rep_hit    = one_held && !any_step && (rep_cnt == rep_int - 32'h1);
  wire [31:0]  rep_half   = {1'b0, rep_int[31:1]};
  wire [31:0]  next_rep_int = (rep_int == 32'(REPEAT_DELAY_CYCLES)) ? 32'(REPEAT_START_CYCLES) :
                              (rep_half < 32'(REPEAT_MIN_CYCLES)) ? 32'(REPEAT_MIN_CYCLES) : rep_half;
  wire         inc_ev     = press[panel_pkg::PIN_INC] || (rep_tick && held[panel_pkg::PIN_INC]);
  wire         dec_ev     = press[panel_pkg::PIN_DEC] || (rep_tick && held[panel_pkg::PIN_DEC]);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      chord_seen <= 1'b0;
    end else if (both_held) begin
      chord_seen <= 1'b1;
    end else if (!held[panel_pkg::PIN_MODE] && !held[panel_pkg::PIN_ENTER]) begin
      chord_seen <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      long_cnt   <= 32'h0;
      long_fired <= 1'b0;
      long_press <= 1'b0;
    end else begin
      long_press <= long_hit;
      if (held[panel_pkg::PIN_ENTER]) begin
        long_cnt   <= long_hit ? 32'h0 : long_cnt + 32'h1;
        long_fired <= long_fired || long_hit;
      end else begin
        long_cnt   <= 32'h0;
        long_fired <= long_fired && !release_ev[panel_pkg::PIN_ENTER];
      end
    end
  end

  // ==========================================================================
  // Auto repeat
  // ==========================================================================
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      rep_cnt  <= 32'h0;
      rep_int  <= 32'(REPEAT_DELAY_CYCLES);
      rep_tick <= 1'b0;
    end else begin
      rep_tick <= rep_hit;
      if (any_step || !one_held) begin
        rep_cnt <= 32'h0;
        rep_int <= 32'(REPEAT_DELAY_CYCLES);
      end else if (rep_hit) begin
        rep_cnt <= 32'h0;
        rep_int <= next_rep_int;
      end else begin
        rep_cnt <= rep_cnt + 32'h1;
      end
    end
  end

  // ==========================================================================
  // Basic mode and parameter editing
  // ==========================================================================
  panel_pkg::basic_mode_e basic_mode;
  panel_pkg::edit_state_e edit_state;
  logic        digit_shift;
  logic [2:0]  pnum;
  logic [15:0] work;
  logic [15:0] param_mem [panel_pkg::N_PARAMS];
  logic        save;

  wire in_param     = (basic_mode == panel_pkg::mode_param);
  wire mode_advance = mode_act && (!in_param || edit_state == panel_pkg::edit_number);
  wire [2:0]  pstep = digit_shift ? panel_pkg::PNUM_SHIFT_STEP : panel_pkg::PNUM_STEP;
  wire [2:0]  next_pnum_up = (pnum > panel_pkg::PNUM_MAX - pstep) ? panel_pkg::PNUM_MAX : pnum + pstep;
  wire [2:0]  next_pnum_dn = (pnum < panel_pkg::PNUM_MIN + pstep) ? panel_pkg::PNUM_MIN : pnum - pstep;
  wire [15:0] vstep = (edit_state == panel_pkg::edit_shift) ? panel_pkg::VALUE_SHIFT_STEP :
                      panel_pkg::VALUE_STEP;
  wire [15:0] next_work_up = (work > panel_pkg::PARAM_MAX - vstep) ? panel_pkg::PARAM_MAX : work + vstep;
  wire [15:0] next_work_dn = (work < panel_pkg::PARAM_MIN + vstep) ? panel_pkg::PARAM_MIN : work - vstep;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      basic_mode <= panel_pkg::mode_status;
    end else if (mode_advance) begin
      case (basic_mode)
        panel_pkg::mode_status:  basic_mode <= panel_pkg::mode_param;
        panel_pkg::mode_param:   basic_mode <= panel_pkg::mode_monitor;
        panel_pkg::mode_monitor: basic_mode <= panel_pkg::mode_utility;
        default:                 basic_mode <= panel_pkg::mode_status;
      endcase
    end
  end

  // ==========================================================================
  // Parameter editing
  // ==========================================================================
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      edit_state  <= panel_pkg::edit_number;
      digit_shift <= 1'b0;
      pnum        <= panel_pkg::PNUM_MIN;
      work        <= panel_pkg::PARAM_MIN;
      save        <= 1'b0;
    end else begin
      save <= 1'b0;
      if (mode_advance) begin
        digit_shift <= 1'b0;
      end
      if (in_param) begin
        case (edit_state)
          panel_pkg::edit_number: begin
            if (chord_ev) begin
              digit_shift <= !digit_shift;
            end else if (inc_ev) begin
              pnum <= next_pnum_up;
            end else if (dec_ev) begin
              pnum <= next_pnum_dn;
            end else if (enter_act) begin
              work       <= param_mem[pnum];
              edit_state <= panel_pkg::edit_value;
            end
          end
          panel_pkg::edit_value: begin
            if (long_press) begin
              edit_state <= panel_pkg::edit_shift;
            end else if (enter_act || mode_act) begin
              save       <= 1'b1;
              edit_state <= panel_pkg::edit_number;
            end else if (inc_ev) begin
              work <= next_work_up;
            end else if (dec_ev) begin
              work <= next_work_dn;
            end
          end
          panel_pkg::edit_shift: begin
            if (mode_act) begin
              save       <= 1'b1;
              edit_state <= panel_pkg::edit_number;
            end else if (enter_act) begin
              edit_state <= panel_pkg::edit_number;
            end else if (inc_ev) begin
              work <= next_work_up;
            end else if (dec_ev) begin
              work <= next_work_dn;
            end
          end
          default: edit_state <= panel_pkg::edit_number;
        endcase
      end else begin
        edit_state <= panel_pkg::edit_number;
      end
    end
  end

  // ==========================================================================
  // Register decode and parameter store
  // ==========================================================================
  wire       param_hit = (i_addr[7:5] == panel_pkg::OFS_PARAM_PAGE) && (i_addr[1:0] == 2'h0);
  wire [2:0] param_idx = i_addr[4:2];
  wire       param_wr  = i_wr && param_hit;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < panel_pkg::N_PARAMS; i++) begin
        param_mem[i] <= panel_pkg::PARAM_RST[i];
      end
    end else if (param_wr) begin
      param_mem[param_idx] <= i_wdata[15:0];
    end else if (save) begin
      param_mem[pnum] <= work;
    end
  end

  // ==========================================================================
  // Status segments and code
  // ==========================================================================
  wire [15:0] speed_win = param_mem[panel_pkg::PIDX_SPEED_WIN];
  wire [15:0] pos_win   = param_mem[panel_pkg::PIDX_POS_WIN];
  wire [15:0] rot_thr   = param_mem[panel_pkg::PIDX_ROT_THR];
  wire [16:0] spd_diff  = {i_motor_speed[15], i_motor_speed} - {i_speed_reference[15], i_speed_reference};
  wire [16:0] spd_err   = spd_diff[16] ? 17'h0 - spd_diff : spd_diff;
  wire [16:0] pos_s     = {i_position_error[15], i_position_error};
  wire [16:0] pos_abs   = pos_s[16] ? 17'h0 - pos_s : pos_s;
  wire [16:0] ref_s     = {i_speed_reference[15], i_speed_reference};
  wire [16:0] ref_abs   = ref_s[16] ? 17'h0 - ref_s : ref_s;
  wire [16:0] trq_s     = {i_torque_reference[15], i_torque_reference};
  wire [16:0] trq_abs   = trq_s[16] ? 17'h0 - trq_s : trq_s;
  wire [16:0] mot_s     = {i_motor_speed[15], i_motor_speed};
  wire [16:0] mot_abs   = mot_s[16] ? 17'h0 - mot_s : mot_s;
  wire        is_pos    = (i_control_mode == panel_pkg::CTL_POSITION);
  wire        is_trq    = (i_control_mode == panel_pkg::CTL_TORQUE);
  wire        seg1      = is_pos ? (pos_abs < {1'b0, pos_win}) :
                          is_trq ? 1'b1 :
                          (spd_err <= {1'b0, speed_win});
  wire        seg2      = i_base_block;
  wire        seg3      = i_control_power_on;
  wire        seg4      = is_pos ? i_ref_pulse_active :
                          (ref_abs > {1'b0, rot_thr});
  wire        seg5      = is_pos ? i_err_clear_input :
                          (trq_abs > {1'b0, panel_pkg::TORQUE_THR_PCT});
  wire        seg6      = i_main_power_ok;
  wire        seg7      = (mot_abs > {1'b0, rot_thr});
  panel_pkg::status_code_e next_code;
  assign next_code = i_alarm_active        ? panel_pkg::code_alarm :
                     !i_forward_overtravel ? panel_pkg::code_fwd_prohibit :
                     !i_reverse_overtravel ? panel_pkg::code_rev_prohibit :
                     i_base_block          ? panel_pkg::code_baseblock :
                                             panel_pkg::code_run;
  wire clear_req = (enter_act && basic_mode == panel_pkg::mode_status) ||
                   press[panel_pkg::PIN_ALARM];

  // ==========================================================================
  // Status registers
  // ==========================================================================
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_status_segments <= 7'h00;
      o_status_code     <= 3'h0;
      o_alarm_code      <= 8'h00;
      o_alarm_clear     <= 1'b0;
    end else begin
      o_status_segments <= {seg7, seg6, seg5, seg4, seg3, seg2, seg1};
      o_status_code     <= next_code;
      o_alarm_code      <= i_alarm_active ? i_alarm_code : 8'h00;
      o_alarm_clear     <= clear_req;
    end
  end

  // ==========================================================================
  // Panel outputs and read port
  // ==========================================================================
  wire [31:0] status_word = (32'(o_status_segments) << panel_pkg::STAT_SEG_LSB) |
                            (32'(o_status_code) << panel_pkg::STAT_CODE_LSB) |
                            (32'(basic_mode) << panel_pkg::STAT_MODE_LSB) |
                            (32'(edit_state) << panel_pkg::STAT_EDIT_LSB) |
                            (32'(digit_shift) << panel_pkg::STAT_SHIFT_BIT);
  wire [31:0] alarm_word  = (32'(i_alarm_active) << panel_pkg::ALARM_ACT_BIT) | 32'(o_alarm_code);
  wire [31:0] panel_word  = (32'(work) << panel_pkg::PANEL_VAL_LSB) | 32'(pnum);
  wire [31:0] read_word   = param_hit                         ? 32'(param_mem[param_idx]) :
                            (i_addr == panel_pkg::OFS_STATUS) ? status_word :
                            (i_addr == panel_pkg::OFS_ALARM)  ? alarm_word :
                            (i_addr == panel_pkg::OFS_PANEL)  ? panel_word : 32'h0;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? read_word : 32'h0;
    end
  end

  // ==========================================================================
  // Display value
  // ==========================================================================
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_display_value <= 16'h0000;
    end else begin
      o_display_value <= (edit_state == panel_pkg::edit_number) ? 16'(pnum) : work;
    end
  end

  assign o_basic_mode   = basic_mode;
  assign o_param_number = pnum;
  assign o_edit_state   = edit_state;
  assign o_digit_shift  = digit_shift;

endmodule // panel_operator_keypad_ui

/* File: rtl/panel_pkg.sv */
/*
  Constants, field layouts and enumerations for the front-panel operator block.
  Assumes a single 40 MHz core clock and a control core on that same clock.
*/
// Function
// - Mode key steps basic mode: status, parameter, monitor, utility, then wraps.
// - After reset the basic mode is status display.
// - Enter key in status display issues an alarm clear request.
// - External alarm reset input also issues an alarm clear request.
// - Speed control: segment 1 lit when speed error within coincidence window.
// - Torque control: segment 1 always lit.
// - Position control: segment 1 lit when position error below positioning window.
// - Segment 3 lit while control power is on.
// - Speed/torque control: segment 4 lit when speed reference exceeds rotation threshold.
// - Speed/torque control: segment 5 lit when torque reference exceeds ten percent.
// - Position control: segment 4 lit while reference pulses arrive.
// - Position control: segment 5 lit while error counter clear is asserted.
// - Segment 6 lit while main circuit power is present and normal.
// - Segment 7 lit when motor speed exceeds rotation threshold.
// - Status code shows baseblock, run, forward or reverse prohibited, or alarm.
// - Parameter mode: increment and decrement keys step the parameter number.
// - Enter on number display shows the selected parameter value.
// - Increment and decrement edit the value, saturating at maximum and minimum.
// - A held increment or decrement key repeats at an accelerating rate.
// - Enter or mode during value display returns to number display.
// - Mode and enter together toggle the number digit-shift state.
// - Long enter on value enters shift edit; mode saves, enter returns.
package panel_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ          = 40_000_000;
  localparam int DEBOUNCE_MS     = 10;
  localparam int LONG_PRESS_MS   = 1000;
  localparam int REPEAT_DELAY_MS = 500;
  localparam int REPEAT_START_MS = 200;
  localparam int REPEAT_MIN_MS   = 25;
  localparam int DEBOUNCE_CYCLES     = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int LONG_PRESS_CYCLES   = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int REPEAT_DELAY_CYCLES = CLK_HZ / 1000 * REPEAT_DELAY_MS;
  localparam int REPEAT_START_CYCLES = CLK_HZ / 1000 * REPEAT_START_MS;
  localparam int REPEAT_MIN_CYCLES   = CLK_HZ / 1000 * REPEAT_MIN_MS;

  // ==========================================================================
  // Pins and parameters
  // ==========================================================================
  localparam int N_PINS    = 5;
  localparam int PIN_INC   = 0;
  localparam int PIN_DEC   = 1;
  localparam int PIN_MODE  = 2;
  localparam int PIN_ENTER = 3;
  localparam int PIN_ALARM = 4;

  localparam int N_PARAMS  = 8;
  localparam logic [2:0]  PNUM_MAX        = 3'h7;
  localparam logic [2:0]  PNUM_MIN        = 3'h0;
  localparam logic [2:0]  PNUM_STEP       = 3'h1;
  localparam logic [2:0]  PNUM_SHIFT_STEP = 3'h4;
  localparam logic [2:0]  PIDX_SPEED_WIN  = 3'h0;
  localparam logic [2:0]  PIDX_POS_WIN    = 3'h1;
  localparam logic [2:0]  PIDX_ROT_THR    = 3'h2;
  localparam logic [15:0] PARAM_MAX         = 16'h270f;
  localparam logic [15:0] PARAM_MIN         = 16'h0000;
  localparam logic [15:0] VALUE_STEP        = 16'h0001;
  localparam logic [15:0] VALUE_SHIFT_STEP  = 16'h000a;
  localparam logic [15:0] TORQUE_THR_PCT    = 16'h000a;
  localparam logic [15:0] PARAM_RST [N_PARAMS] = '{16'h000a, 16'h000a, 16'h0014, 16'h0000,
                                                   16'h0000, 16'h0000, 16'h0000, 16'h0000};

  localparam logic [1:0] CTL_SPEED    = 2'h0;
  localparam logic [1:0] CTL_TORQUE   = 2'h1;
  localparam logic [1:0] CTL_POSITION = 2'h2;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS     = 8'h00;
  localparam logic [7:0] OFS_ALARM      = 8'h04;
  localparam logic [7:0] OFS_PANEL      = 8'h08;
  localparam logic [7:0] OFS_PARAM_BASE = 8'h20;
  localparam logic [2:0] OFS_PARAM_PAGE = 3'h1;
  localparam int STAT_SEG_LSB   = 0;
  localparam int STAT_CODE_LSB  = 8;
  localparam int STAT_MODE_LSB  = 12;
  localparam int STAT_EDIT_LSB  = 16;
  localparam int STAT_SHIFT_BIT = 20;
  localparam int ALARM_ACT_BIT  = 8;
  localparam int PANEL_VAL_LSB  = 16;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [1:0] {mode_status, mode_param, mode_monitor, mode_utility} basic_mode_e;
  typedef enum logic [2:0] {code_baseblock, code_run, code_fwd_prohibit, code_rev_prohibit,
                            code_alarm} status_code_e;
  typedef enum logic [1:0] {edit_number, edit_value, edit_shift} edit_state_e;

endpackage

/* File: dv/panel_props.sv */
/* Checker of panel outputs against their causes.
   Assumes it is bound to the panel top on its single clock. */
`timescale 1ns/1ps
module panel_props (
  input wire logic       i_core_clk, i_rst_b, i_base_block, i_control_power_on, i_main_power_ok,
  input wire logic       i_ref_pulse_active, i_err_clear_input, i_alarm_active, o_alarm_clear,
  input wire logic [1:0] i_control_mode, o_basic_mode,
  input wire logic [7:0] i_alarm_code, o_alarm_code,
  input wire logic [6:0] o_status_segments,
  input wire logic [2:0] o_status_code
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  base_block_seg_a: assert property ($past(i_rst_b) |-> o_status_segments[1] == $past(i_base_block))
    else $error("base block segment wrong");
  ctl_power_seg_a: assert property ($past(i_rst_b) |-> o_status_segments[2] == $past(i_control_power_on))
    else $error("control power segment wrong");
  main_power_seg_a: assert property ($past(i_rst_b) |-> o_status_segments[5] == $past(i_main_power_ok))
    else $error("power ready segment wrong");
  torque_seg_a: assert property ($past(i_rst_b) && $past(i_control_mode) == 2'h1 |-> o_status_segments[0])
    else $error("torque coincidence segment dark");
  pulse_seg_a: assert property ($past(i_rst_b) && $past(i_control_mode) == 2'h2 |->
    o_status_segments[3] == $past(i_ref_pulse_active)) else $error("pulse segment wrong");
  clear_seg_a: assert property ($past(i_rst_b) && $past(i_control_mode) == 2'h2 |->
    o_status_segments[4] == $past(i_err_clear_input)) else $error("clear segment wrong");
  alarm_code_a: assert property ($past(i_rst_b) && $past(i_alarm_active) |->
    o_status_code == 3'h4 && o_alarm_code == $past(i_alarm_code)) else $error("alarm code wrong");
  clear_pulse_a: assert property (o_alarm_clear |=> !o_alarm_clear) else $error("clear pulse too long");
  mode_step_a: assert property (o_basic_mode != $past(o_basic_mode) |->
    o_basic_mode == $past(o_basic_mode) + 2'h1) else $error("basic mode skipped");
endmodule // panel_props
bind panel_operator_keypad_ui panel_props u_props (.*);

/* File: dv/panel_operator.sv */
/* Operator at the front panel keys.
   Assumes key levels high while pressed. */
`timescale 1ns/1ps
module panel_operator (
  input  wire logic clk,
  output logic [4:0] keys
);
  initial keys = '0;
  // Hold long enough to pass synchroniser and debounce
  task automatic press(input logic [4:0] k);
    hold(k, 12);
  endtask
  // Hold keys for n cycles, then wait until the release has passed debounce
  task automatic hold(input logic [4:0] k, input int n);
    @(posedge clk); keys <= k;
    repeat (n) @(posedge clk); keys <= '0;
    repeat (14) @(posedge clk); #1;
  endtask
endmodule // panel_operator

/* File: dv/testbench.sv */
/* Self-checking bench of the panel block.
   Assumes the operator model drives the key pins. */
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst_b, wr, rd, pls, clr, bb, cp, mp, fwd, rev, alm;
  logic [1:0] ctl, bmode, est;
  logic [15:0] ms, sr, tq, pe, dval;
  logic [7:0] addr, acode, ocode;
  logic [31:0] wdata, rdata, d;
  logic [6:0] segs;
  logic [2:0] code, pnum;
  logic [4:0] keys;
  logic oclr, dsh;
  int fails = 0, cmp_count = 0, nclr = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (oclr) nclr++;
  panel_operator OP (.clk(clk), .keys(keys));
  panel_operator_keypad_ui #(.DEBOUNCE_CYCLES(4), .LONG_PRESS_CYCLES(50), .REPEAT_DELAY_CYCLES(40),
    .REPEAT_START_CYCLES(16), .REPEAT_MIN_CYCLES(4)) DUT (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_increment_key(keys[0]), .i_decrement_key(keys[1]), .i_mode_key(keys[2]), .i_enter_key(keys[3]),
    .i_alarm_reset_input(keys[4]), .i_control_mode(ctl), .i_motor_speed(ms), .i_speed_reference(sr),
    .i_torque_reference(tq), .i_position_error(pe), .i_ref_pulse_active(pls), .i_err_clear_input(clr),
    .i_base_block(bb), .i_control_power_on(cp), .i_main_power_ok(mp), .i_forward_overtravel(fwd),
    .i_reverse_overtravel(rev), .i_alarm_active(alm), .i_alarm_code(acode), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_basic_mode(bmode), .o_status_segments(segs), .o_status_code(code),
    .o_alarm_code(ocode), .o_alarm_clear(oclr), .o_param_number(pnum), .o_display_value(dval),
    .o_edit_state(est), .o_digit_shift(dsh));
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end
  endtask
  task rdr(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1; @(posedge clk); rd <= 0; #1 v = rdata;
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1; @(posedge clk); wr <= 0;
  endtask
  function int ab(input logic signed [15:0] v); return v < 0 ? -int'(v) : int'(v); endfunction
  function logic [6:0] seg_exp();
    logic s1;
    s1 = ctl == 2'h1 ? 1'b1 : ctl == 2'h2 ? ab(pe) < 10 : ab(ms - sr) <= 10;
    return {ab(ms) > 20, mp, ctl == 2'h2 ? clr : ab(tq) > 10, ctl == 2'h2 ? pls : ab(sr) > 20, cp, bb, s1};
  endfunction
  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin #(25 * 20000); fails++; final_report(); end
  initial begin
    {rst_b, wr, rd, pls, clr, bb, cp, mp, alm, ctl} <= '0;
    {fwd, rev} <= 2'h3;
    {ms, sr, tq, pe, addr, acode, wdata} <= '0;
    void'($urandom(40));
    repeat (12) @(posedge clk); rst_b <= 1; @(posedge clk); #1;
    chk(bmode, 0);
    for (int i = 1; i < 5; i++) begin OP.press(5'h04); chk(bmode, i % 4); end
    OP.press(5'h08); chk(nclr, 1);
    OP.press(5'h10); chk(nclr, 2);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk); ctl <= $urandom; ms <= $urandom_range(60) - 30; sr <= $urandom_range(60) - 30;
      tq <= $urandom_range(30) - 15; pe <= $urandom_range(30) - 15; acode <= $urandom;
      {pls, clr, bb, cp, mp, fwd, rev, alm} <= $urandom;
      repeat (2) @(posedge clk); #1 chk(segs, seg_exp());
      chk(code, alm ? 3'h4 : !fwd ? 3'h2 : !rev ? 3'h3 : bb ? 3'h0 : 3'h1);
      chk(ocode, alm ? acode : 8'h00);
    end
    rdr(8'h10, d); chk(d, 0);
    rdr(8'h20, d); chk(d, 32'h0000000a);
    wrr(8'h28, 32'h00000015); rdr(8'h28, d); chk(d, 32'h00000015);
    OP.press(5'h04); OP.press(5'h01); chk(pnum, 1);
    OP.press(5'h08); chk(est, 1); chk(dval, 16'h000a);
    repeat (11) OP.press(5'h02); chk(dval, 0);
    OP.press(5'h08); chk(est, 0); rdr(8'h24, d); chk(d, 0);
    OP.press(5'h0c); chk(dsh, 1);
    OP.press(5'h01); chk(pnum, 5);
    OP.press(5'h0c); chk(dsh, 0);
    OP.press(5'h08); OP.hold(5'h08, 60); chk(est, 2);
    OP.press(5'h01); chk(dval, 16'h000a);
    OP.press(5'h04); chk(est, 0); chk(bmode, 1); rdr(8'h34, d); chk(d, 32'h0000000a);
    OP.press(5'h08); OP.hold(5'h01, 79); chk(dval, 16'h0011);
    OP.press(5'h04); rdr(8'h34, d); chk(d, 32'h00000011);
    final_report();
  end
endmodule // testbench
